// ===== serializer_output_channel_config_tb.sv
`timescale 1ns/1ps
module serializer_output_channel_config_tb
   import soc_pkg::*;
;
   localparam logic [6:0] DEV = 7'h5A;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} soc_row_s;
   logic       sys_clk, reset_n, scl, host_low, sda_oe, pin_en, scr_def, ok;
   logic       term, pri_en, red_en, tx_act, fo_sel, gpio, psave, scr_en, sda_out;
   logic [1:0] link;
   logic [2:0] dly;
   logic [3:0] amp;
   logic [7:0] rd;
   int         mismatches, total_checks;
   // Open-drain data line with pull-up
   wire        sda_wire = ~(host_low | sda_oe);
   // Ordinary register cases: address, written, read back
   soc_row_s   rows [8] = '{'{8'h2F, 8'hFF, 8'h3F}, '{8'h30, 8'hFF, 8'hE2},
      '{8'h30, 8'h1D, 8'h02}, '{8'h69, 8'hFF, 8'h07}, '{8'h69, 8'hF8, 8'h00},
      '{8'h50, 8'hAA, 8'h00}, '{8'h04, 8'h21, 8'h21}, '{8'h22, 8'h08, 8'h08}};
   logic [3:0] lvl [8] = '{4'h7, 4'h8, 4'h5, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1};
   // Config byte, pin, expected primary and redundant enables
   logic [10:0] en_rows [7] = '{{8'h24, 3'b100}, {8'h27, 3'b111}, {8'h26, 3'b101},
      {8'h25, 3'b110}, {8'h27, 3'b010}, {8'h20, 3'b010}, {8'h20, 3'b111}};

   soc_output_config DUT (
      .sys_clk(sys_clk), .reset_n(reset_n), .smb_scl(scl), .smb_sda_in(sda_wire),
      .smb_sda_out(sda_out), .smb_sda_oe(sda_oe), .redundant_output_pin_enable(pin_en),
      .link_detect(link), .scrambler_default(scr_def), .termination_50_ohm(term),
      .primary_serial_output_enable(pri_en), .redundant_serial_output_enable(red_en),
      .transmit_active(tx_act), .failover_select(fo_sel),
      .parallel_input_clock_delay(dly), .amplitude_level(amp),
      .serial_clock_to_general_purpose_pin_two(gpio), .power_save(psave),
      .scrambler_enable(scr_en));

   soc_smb_host host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(host_low));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.write_reg(DEV, a, d, ok);
      check({7'h0, ok}, 8'h01, "write ack");
      host.cyc(8);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.read_reg(DEV, a, rd, ok);
      check({7'h0, ok}, 8'h01, "read ack");
      check(rd, e, "read data");
   endtask

   // Drives link status and checks the transmit state after sync delay
   task automatic lk(input logic [1:0] l, input logic e);
      link <= l;
      host.cyc(8);
      check({7'h0, tx_act}, {7'h0, e}, "transmit active");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (80000) @(posedge sys_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      reset_n = 1'b0;
      pin_en = 1'b1;
      link = 2'b00;
      scr_def = 1'b1;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      host.cyc(6);
      check({7'h0, term}, 8'h01, "termination");
      check({6'h0, pri_en, red_en}, 8'h03, "enables");
      check({5'h0, dly}, 8'h03, "delay");
      check({4'h0, amp}, 8'h06, "level");
      check({7'h0, sda_out}, 8'h00, "data out level");
      rdchk(ADDR_TX_CFG, 8'h38);
      rdchk(ADDR_CLK_DLY, 8'h62);
      rdchk(ADDR_SWING, 8'h03);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].e);
      end
      $display("test table done");
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_SWING, 8'(c));
         check({4'h0, amp}, {4'h0, lvl[c]}, "level");
         wr(ADDR_CLK_DLY, {3'(c), 5'h00});
         check({5'h0, dly}, {5'h0, 3'(c)}, "delay");
      end
      $display("test codes done");
      wr(ADDR_TX_CFG, 8'h38);
      lk(2'b01, 1'b0);
      lk(2'b11, 1'b1);
      lk(2'b10, 1'b0);
      wr(ADDR_TX_CFG, 8'h20);
      lk(2'b10, 1'b1);
      lk(2'b01, 1'b1);
      lk(2'b00, 1'b0);
      $display("test link done");
      foreach (en_rows[i]) begin
         pin_en <= en_rows[i][2];
         wr(ADDR_TX_CFG, en_rows[i][10:3]);
         check({6'h0, pri_en, red_en}, {6'h0, en_rows[i][1:0]}, "enables");
      end
      wr(ADDR_TX_CFG, 8'h00);
      check({7'h0, term}, 8'h00, "termination");
      wr(ADDR_TX_CFG, 8'h20);
      check({7'h0, term}, 8'h01, "termination");
      $display("test outputs done");
      wr(ADDR_GPIO, 8'h21);
      check({7'h0, gpio}, 8'h01, "clock route");
      wr(ADDR_GPIO, 8'h20);
      check({7'h0, gpio}, 8'h00, "clock route");
      wr(ADDR_PWR_A, 8'h10);
      check({7'h0, psave}, 8'h00, "power save");
      wr(ADDR_PWR_B, 8'h40);
      check({7'h0, psave}, 8'h01, "power save");
      wr(ADDR_PWR_A, 8'h00);
      check({7'h0, psave}, 8'h00, "power save");
      wr(ADDR_SCR_OVR, 8'h00);
      check({7'h0, scr_en}, 8'h01, "scrambler");
      wr(ADDR_SCR_OVR, 8'h08);
      check({7'h0, scr_en}, 8'h00, "scrambler");
      wr(ADDR_SCR_CTL, 8'h08);
      check({7'h0, scr_en}, 8'h01, "scrambler");
      // Override holds against a changed default, then default takes over
      scr_def <= 1'b0;
      host.cyc(6);
      check({7'h0, scr_en}, 8'h01, "scrambler");
      wr(ADDR_SCR_OVR, 8'h00);
      check({7'h0, scr_en}, 8'h00, "scrambler");
      $display("test recipes done");
      pin_en <= 1'b1;
      link <= 2'b11;
      wr(ADDR_TX_CFG, 8'h2D);
      wr(ADDR_TX_CFG, 8'h28);
      check({7'h0, fo_sel}, 8'h00, "failover");
      link <= 2'b10;
      host.cyc(8);
      check({7'h0, fo_sel}, 8'h01, "failover");
      link <= 2'b11;
      host.cyc(8);
      link <= 2'b01;
      host.cyc(8);
      check({7'h0, fo_sel}, 8'h00, "failover");
      $display("test failover done");
      // Foreign address is not acknowledged and changes nothing
      host.write_reg(7'h3C, ADDR_TX_CFG, 8'h00, ok);
      check({7'h0, ok}, 8'h00, "foreign ack");
      rdchk(ADDR_TX_CFG, 8'h28);
      // Reset in mid-run restores defaults
      reset_n <= 1'b0;
      host.cyc(2);
      check({5'h0, dly}, 8'h03, "delay");
      reset_n <= 1'b1;
      host.cyc(6);
      rdchk(ADDR_TX_CFG, 8'h38);
      $display("test refusal and reset done");
      finish_test();
   end
endmodule

// ===== soc_output_config.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Bit 5 picks 50 or 75 ohm termination
// R2 - Start bit: either link or both links
// R3 - Stop bit: both invalid or either invalid
// R4 - No override: primary on, redundant follows pin
// R5 - Override: bits 1 and 0 enable outputs
// R6 - Pin must be high for redundant output
// R7 - Bits 7:5 set input clock delay code
// R8 - Swing code maps to output level table
// R9 - Power save needs several writes to change
// R10 - Scrambler override needs two register writes
// R11 - Value 0x21 in 0x04 routes clock
// R12 - Two writes enter power save, undo exits
// R13 - Failover config swaps to alternate live link
// R14 - Reserved bits ignore writes, read defaults
module soc_output_config
   import soc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h5A
) (
   input  logic       sys_clk,
   input  logic       reset_n,
   input  logic       smb_scl,
   input  logic       smb_sda_in,
   output logic       smb_sda_out,
   output logic       smb_sda_oe,
   input  logic       redundant_output_pin_enable,
   input  logic [1:0] link_detect,
   input  logic       scrambler_default,
   output logic       termination_50_ohm,
   output logic       primary_serial_output_enable,
   output logic       redundant_serial_output_enable,
   output logic       transmit_active,
   output logic       failover_select,
   output logic [2:0] parallel_input_clock_delay,
   output logic [3:0] amplitude_level,
   output logic       serial_clock_to_general_purpose_pin_two,
   output logic       power_save,
   output logic       scrambler_enable
);
   typedef struct packed {
      logic [5:0] tx_cfg;
      logic [2:0] clk_dly;
      logic [2:0] swing;
      logic [7:0] pwr_a, gpio_sel, scr_ctl, scr_ovr, pwr_b;
      logic       pin_s1, pin_s2;
      logic [1:0] link_s1, link_s2;
      logic       scr_s1, scr_s2;
      logic       active, cur_ch;
      logic       term50, pri_en, red_en;
      logic [2:0] dly_code;
      logic [3:0] amp_lvl;
      logic       gpio_clk, pwr_save, scr_en, sda_out;
   } soc_top_s;

   localparam soc_top_s TOP_RST = '{tx_cfg: TX_CFG_RST, clk_dly: CLK_DLY_RST,
      swing: SWING_RST, term50: TX_CFG_RST[TX_TERM_BIT], pri_en: 1'b1,
      dly_code: CLK_DLY_RST, amp_lvl: AMP_LEVEL_TBL[SWING_RST], default: '0};

   soc_top_s  st, nx;
   soc_reg_if bus ();
   logic      ovr, both_up, any_up, start_ok, stop_now, fo_mode;

   // Serial bus slave feeding the register bank
   soc_smb_slave #(
      .DEV_ADDR (DEV_ADDR)
   ) u_smb (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .smb_scl    (smb_scl),
      .smb_sda_in (smb_sda_in),
      .smb_sda_oe (smb_sda_oe),
      .bus        (bus)
   );

   // Read mux; reserved fields return their fixed defaults
   always_comb begin
      case (bus.rd_addr)
         ADDR_TX_CFG:  bus.rd_data = {2'h0, st.tx_cfg};          // [R14]
         ADDR_CLK_DLY: bus.rd_data = {st.clk_dly, CLK_DLY_RSVD}; // [R14]
         ADDR_SWING:   bus.rd_data = {5'h00, st.swing};          // [R14]
         ADDR_PWR_A:   bus.rd_data = st.pwr_a;
         ADDR_GPIO:    bus.rd_data = st.gpio_sel;
         ADDR_SCR_CTL: bus.rd_data = st.scr_ctl;
         ADDR_SCR_OVR: bus.rd_data = st.scr_ovr;
         ADDR_PWR_B:   bus.rd_data = st.pwr_b;
         default:      bus.rd_data = 8'h00;
      endcase
   end

   // Link qualifiers from the synchronised remote sense inputs
   assign ovr      = st.tx_cfg[TX_OVR_BIT];
   assign both_up  = &st.link_s2;
   assign any_up   = |st.link_s2;
   assign start_ok = st.tx_cfg[TX_START_BIT] ? both_up : any_up;      // [R2]
   assign stop_now = st.tx_cfg[TX_STOP_BIT] ? !both_up : !any_up;     // [R3]
   assign fo_mode  = !ovr && !st.tx_cfg[TX_START_BIT] && st.pin_s2;

   // Register writes, synchronisers, link state and output stage
   always_comb begin
      nx         = st;
      nx.pin_s1  = redundant_output_pin_enable;
      nx.pin_s2  = st.pin_s1;
      nx.link_s1 = link_detect;
      nx.link_s2 = st.link_s1;
      nx.scr_s1  = scrambler_default;
      nx.scr_s2  = st.scr_s1;
      if (bus.wr_en) begin
         case (bus.wr_addr)
            ADDR_TX_CFG:  nx.tx_cfg = bus.wr_data[5:0];            // [R14]
            ADDR_CLK_DLY: nx.clk_dly = bus.wr_data[7:CLK_DLY_LSB]; // [R7]
            ADDR_SWING:   nx.swing = bus.wr_data[2:0];             // [R14]
            ADDR_PWR_A:   nx.pwr_a = bus.wr_data;
            ADDR_GPIO:    nx.gpio_sel = bus.wr_data;
            ADDR_SCR_CTL: nx.scr_ctl = bus.wr_data;
            ADDR_SCR_OVR: nx.scr_ovr = bus.wr_data;
            ADDR_PWR_B:   nx.pwr_b = bus.wr_data;
            default: ;
         endcase
      end
      // Transmission start and stop policy
      if (st.active) begin
         nx.active = !stop_now; // [R3]
      end else begin
         nx.active = start_ok;  // [R2]
      end
      // Swap to the other channel when the current link drops
      if (!fo_mode) begin
         nx.cur_ch = 1'b0;
      end else if (!st.link_s2[st.cur_ch] && st.link_s2[!st.cur_ch]) begin
         nx.cur_ch = !st.cur_ch; // [R13]
      end
      nx.term50   = st.tx_cfg[TX_TERM_BIT]; // [R1]
      nx.pri_en   = ovr ? st.tx_cfg[TX_PRI_EN_BIT] : 1'b1; // [R4] [R5]
      nx.red_en   = (ovr ? st.tx_cfg[TX_RED_EN_BIT] : 1'b1) & st.pin_s2; // [R4] [R5] [R6]
      nx.dly_code = st.clk_dly;                // [R7]
      nx.amp_lvl  = AMP_LEVEL_TBL[st.swing];   // [R8]
      nx.gpio_clk = st.gpio_sel == GPIO_CLK_VAL; // [R11]
      nx.pwr_save = st.pwr_a == PWR_A_VAL && st.pwr_b == PWR_B_VAL; // [R9] [R12]
      nx.scr_en   = st.scr_ovr == SCR_OVR_VAL ? st.scr_ctl[SCR_EN_BIT] : st.scr_s2; // [R10]
      nx.sda_out  = 1'b0;
   end

   // State register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= TOP_RST;
      end else begin
         st <= nx;
      end
   end

   assign smb_sda_out                             = st.sda_out;
   assign termination_50_ohm                      = st.term50;
   assign primary_serial_output_enable            = st.pri_en;
   assign redundant_serial_output_enable          = st.red_en;
   assign transmit_active                         = st.active;
   assign failover_select                         = st.cur_ch;
   assign parallel_input_clock_delay              = st.dly_code;
   assign amplitude_level                         = st.amp_lvl;
   assign serial_clock_to_general_purpose_pin_two = st.gpio_clk;
   assign power_save                              = st.pwr_save;
   assign scrambler_enable                        = st.scr_en;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_wr(logic [7:0] a);
      bus.wr_en && bus.wr_addr == a;
   endsequence
   sequence s_pwr_armed;
      st.pwr_a == PWR_A_VAL && st.pwr_b == PWR_B_VAL;
   endsequence
   sequence s_link_lost;
      fo_mode && !st.link_s2[st.cur_ch] && st.link_s2[!st.cur_ch];
   endsequence

   property p_term;
      s_wr(ADDR_TX_CFG) |-> ##2 termination_50_ohm == $past(bus.wr_data[TX_TERM_BIT], 2);
   endproperty
   a_term: assert property (p_term) else $error("termination not from write"); // [R1]

   property p_start_both;
      !transmit_active && st.tx_cfg[TX_START_BIT] && !both_up |=> !transmit_active;
   endproperty
   a_start_both: assert property (p_start_both) else $error("early start"); // [R2]

   property p_start_any;
      !transmit_active && !st.tx_cfg[TX_START_BIT] && any_up |=> transmit_active;
   endproperty
   a_start_any: assert property (p_start_any) else $error("missed start"); // [R2]

   property p_stop_either;
      transmit_active && st.tx_cfg[TX_STOP_BIT] && !both_up |=> !transmit_active;
   endproperty
   a_stop_either: assert property (p_stop_either) else $error("missed stop"); // [R3]

   property p_stop_both;
      transmit_active && !st.tx_cfg[TX_STOP_BIT] && any_up |=> transmit_active;
   endproperty
   a_stop_both: assert property (p_stop_both) else $error("early stop"); // [R3]

   property p_no_ovr;
      !ovr |=> primary_serial_output_enable &&
               redundant_serial_output_enable == $past(st.pin_s2);
   endproperty
   a_no_ovr: assert property (p_no_ovr) else $error("default enables wrong"); // [R4]

   property p_ovr;
      ovr |=> primary_serial_output_enable == $past(st.tx_cfg[TX_PRI_EN_BIT]) &&
              redundant_serial_output_enable ==
              $past(st.tx_cfg[TX_RED_EN_BIT] && st.pin_s2);
   endproperty
   a_ovr: assert property (p_ovr) else $error("override enables wrong"); // [R5]

   property p_delay;
      s_wr(ADDR_CLK_DLY) |-> ##2 parallel_input_clock_delay == $past(bus.wr_data[7:5], 2);
   endproperty
   a_delay: assert property (p_delay) else $error("delay code not applied"); // [R7]

   property p_amp;
      st.swing == 3'h1 |=> amplitude_level == 4'h8;
   endproperty
   a_amp: assert property (p_amp) else $error("amplitude map wrong"); // [R8]

   property p_pwr_on;
      s_pwr_armed |=> power_save;
   endproperty
   a_pwr_on: assert property (p_pwr_on) else $error("power save missed"); // [R12]

   property p_pwr_single;
      !(st.pwr_a == PWR_A_VAL && st.pwr_b == PWR_B_VAL) |=> !power_save;
   endproperty
   a_pwr_single: assert property (p_pwr_single) else $error("one write changed mode"); // [R9]

   property p_gpio;
      s_wr(ADDR_GPIO) ##1 st.gpio_sel == GPIO_CLK_VAL |=>
         serial_clock_to_general_purpose_pin_two;
   endproperty
   a_gpio: assert property (p_gpio) else $error("clock not routed"); // [R11]

   property p_failover;
      s_link_lost |=> failover_select != $past(failover_select);
   endproperty
   a_failover: assert property (p_failover) else $error("no failover"); // [R13]

   property p_rsvd;
      bus.rd_addr == ADDR_CLK_DLY |-> bus.rd_data[4:0] == CLK_DLY_RSVD;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits changed"); // [R14]
endmodule

// ===== soc_pkg.sv
package soc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_PWR_A   = 8'h01;
   localparam logic [7:0] ADDR_GPIO    = 8'h04;
   localparam logic [7:0] ADDR_SCR_CTL = 8'h21;
   localparam logic [7:0] ADDR_SCR_OVR = 8'h22;
   localparam logic [7:0] ADDR_PWR_B   = 8'h26;
   localparam logic [7:0] ADDR_TX_CFG  = 8'h2F;
   localparam logic [7:0] ADDR_CLK_DLY = 8'h30;
   localparam logic [7:0] ADDR_SWING   = 8'h69;
   // Field positions in the transmit output, scrambler control and clock delay registers
   localparam int TX_TERM_BIT   = 5;
   localparam int TX_START_BIT  = 4;
   localparam int TX_STOP_BIT   = 3;
   localparam int TX_OVR_BIT    = 2;
   localparam int TX_RED_EN_BIT = 1;
   localparam int TX_PRI_EN_BIT = 0;
   localparam int SCR_EN_BIT    = 3;
   localparam int CLK_DLY_LSB   = 5;
   // Values after reset
   localparam logic [5:0] TX_CFG_RST   = 6'h38;
   localparam logic [2:0] CLK_DLY_RST  = 3'h3;
   localparam logic [4:0] CLK_DLY_RSVD = 5'h02;
   localparam logic [2:0] SWING_RST    = 3'h3;
   // Clock routing and multi-write trigger values
   localparam logic [7:0] GPIO_CLK_VAL = 8'h21;
   localparam logic [7:0] PWR_A_VAL    = 8'h10;
   localparam logic [7:0] PWR_B_VAL    = 8'h40;
   localparam logic [7:0] SCR_OVR_VAL  = 8'h08;
   // Swing code to output level, entry 0 rightmost
   localparam logic [7:0][3:0] AMP_LEVEL_TBL =
      {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h5, 4'h8, 4'h7};
   localparam logic [3:0] SMB_BITS = 4'h8;
   // Serial bus slave states
   typedef enum logic [2:0] {
      SMB_IDLE, SMB_ADDR, SMB_ACK_A, SMB_WRITE, SMB_ACK_W, SMB_READ, SMB_ACK_R
   } soc_smb_state_e;
endpackage

// ===== soc_reg_if.sv
`timescale 1ns/1ps
interface soc_reg_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport slave (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport bank (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ===== soc_smb_host.sv
`timescale 1ns/1ps
// SMBus master standing in for the system host; data bits move only while SCL is low
module soc_smb_host (
   input  wire logic sys_clk,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   // Idle bus: clock high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // Waits whole clock cycles
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // One bit slot; phases well above the 4-cycle minimum
   task automatic bit_io(input logic b, output logic r);
      cyc(4);
      sda_low <= ~b;
      cyc(6);
      scl <= 1'b1;
      cyc(6);
      r = sda_wire;
      scl <= 1'b0;
   endtask

   // Start or repeated start: data falls while clock is high
   task automatic start();
      cyc(4);
      sda_low <= 1'b0;
      cyc(6);
      scl <= 1'b1;
      cyc(6);
      sda_low <= 1'b1;
      cyc(6);
      scl <= 1'b0;
   endtask

   // Stop: data rises while clock is high
   task automatic stop();
      cyc(4);
      sda_low <= 1'b1;
      cyc(6);
      scl <= 1'b1;
      cyc(6);
      sda_low <= 1'b0;
      cyc(6);
   endtask

   // Byte out MSB first, then the device acknowledge slot
   task automatic send(input logic [7:0] b, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ok = ~r;
   endtask

   // Byte in MSB first; last byte gets a not-acknowledge
   task automatic recv(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(last, r);
   endtask

   // Pointer then one data byte
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] d, output logic ok);
      logic a, b, c;
      start();
      send({dev, 1'b0}, a);
      send(ptr, b);
      send(d, c);
      stop();
      ok = a & b & c;
   endtask

   // Pointer write, repeated start, one byte read
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [7:0] d, output logic ok);
      logic a, b, c;
      start();
      send({dev, 1'b0}, a);
      send(ptr, b);
      start();
      send({dev, 1'b1}, c);
      recv(1'b1, d);
      stop();
      ok = a & b & c;
   endtask
endmodule

// ===== soc_smb_slave.sv
`timescale 1ns/1ps
module soc_smb_slave
   import soc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h5A
) (
   input  logic    sys_clk,
   input  logic    reset_n,
   input  logic    smb_scl,
   input  logic    smb_sda_in,
   output logic    smb_sda_oe,
   soc_reg_if.slave bus
);
   typedef struct packed {
      logic           scl_s1, scl_s2, scl_d;
      logic           sda_s1, sda_s2, sda_d;
      soc_smb_state_e state;
      logic [3:0]     bit_cnt;
      logic [7:0]     shreg;
      logic [7:0]     ptr;
      logic           rw, first, sda_oe;
      logic           wr_en;
      logic [7:0]     wr_addr, wr_data;
   } soc_smb_s;

   soc_smb_s r, n;
   logic     rise, fall, start, stop;

   // Edge and bus condition detection on synchronised pins
   assign rise  = r.scl_s2 & ~r.scl_d;
   assign fall  = ~r.scl_s2 & r.scl_d;
   assign start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
   assign stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

   // Byte engine: pointer byte first, then data with auto increment
   always_comb begin
      n        = r;
      n.wr_en  = 1'b0;
      n.scl_s1 = smb_scl;
      n.scl_s2 = r.scl_s1;
      n.scl_d  = r.scl_s2;
      n.sda_s1 = smb_sda_in;
      n.sda_s2 = r.sda_s1;
      n.sda_d  = r.sda_s2;
      if (start) begin
         n.state   = SMB_ADDR;
         n.bit_cnt = '0;
         n.sda_oe  = 1'b0;
         n.first   = 1'b1;
      end else if (stop) begin
         n.state  = SMB_IDLE;
         n.sda_oe = 1'b0;
      end else if (rise) begin
         case (r.state)
            SMB_ADDR, SMB_WRITE: begin
               n.shreg   = {r.shreg[6:0], r.sda_s2};
               n.bit_cnt = 4'(r.bit_cnt + 4'h1);
            end
            SMB_ACK_R: if (r.sda_s2) n.state = SMB_IDLE; // Master NACK ends read
            default: ;
         endcase
      end else if (fall) begin
         case (r.state)
            SMB_ADDR: if (r.bit_cnt == SMB_BITS) begin
               if (r.shreg[7:1] == DEV_ADDR) begin
                  n.sda_oe = 1'b1;
                  n.rw     = r.shreg[0];
                  n.state  = SMB_ACK_A;
               end else begin
                  n.state = SMB_IDLE;
               end
            end
            SMB_WRITE: if (r.bit_cnt == SMB_BITS) begin
               n.sda_oe = 1'b1;
               n.state  = SMB_ACK_W;
               if (r.first) begin
                  n.ptr   = r.shreg;
                  n.first = 1'b0;
               end else begin
                  n.wr_en   = 1'b1;
                  n.wr_addr = r.ptr;
                  n.wr_data = r.shreg;
                  n.ptr     = 8'(r.ptr + 8'h01);
               end
            end
            SMB_ACK_A, SMB_ACK_W, SMB_ACK_R: begin
               if (r.state != SMB_ACK_R && !(r.state == SMB_ACK_A && r.rw)) begin
                  n.sda_oe  = 1'b0;
                  n.state   = SMB_WRITE;
                  n.bit_cnt = '0;
               end else begin
                  n.shreg   = {bus.rd_data[6:0], 1'b0};
                  n.sda_oe  = ~bus.rd_data[7];
                  n.bit_cnt = 4'h1;
                  n.state   = SMB_READ;
               end
            end
            SMB_READ: begin
               if (r.bit_cnt == SMB_BITS) begin
                  n.sda_oe = 1'b0;
                  n.state  = SMB_ACK_R;
                  n.ptr    = 8'(r.ptr + 8'h01);
               end else begin
                  n.sda_oe  = ~r.shreg[7];
                  n.shreg   = {r.shreg[6:0], 1'b0};
                  n.bit_cnt = 4'(r.bit_cnt + 4'h1);
               end
            end
            default: n.sda_oe = 1'b0;
         endcase
      end
   end

   // State register; idle bus reads high
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1,
                sda_s2: 1'b1, sda_d: 1'b1, state: SMB_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   assign smb_sda_oe  = r.sda_oe;
   assign bus.wr_en   = r.wr_en;
   assign bus.wr_addr = r.wr_addr;
   assign bus.wr_data = r.wr_data;
   assign bus.rd_addr = r.ptr;
endmodule
